/* irq_event_pkg.sv */
// Constants, bit layout and carrier types for the low interrupt event bits
package irq_event_pkg;

   localparam int EV_W = 21;
   localparam int DATA_W = 32;
   localparam int ADDR_W = 8;

   // Register window offsets
   localparam logic [ADDR_W-1:0] OFF_EVENT_SET = 8'h80;
   localparam logic [ADDR_W-1:0] OFF_EVENT_CLR = 8'h84;

   // Bit positions
   localparam int BIT_NEW_CYCLE = 20;
   localparam int BIT_PHY_REQ = 19;
   localparam int BIT_BUS_REINIT = 17;
   localparam int BIT_ID_DONE = 16;
   localparam int BIT_LOCK_FAIL = 9;
   localparam int BIT_BUF_WR_FAIL = 8;
   localparam int BIT_RX_SUMMARY = 7;
   localparam int BIT_TX_SUMMARY = 6;
   localparam int BIT_REPLY_PKT = 5;
   localparam int BIT_REQUEST_PKT = 4;
   localparam int BIT_REPLY_RX_DMA = 3;
   localparam int BIT_REQUEST_RX_DMA = 2;
   localparam int BIT_REPLY_SEND = 1;
   localparam int BIT_REQUEST_SEND = 0;

   // Latched bits, and every bit that may read nonzero
   localparam logic [EV_W-1:0] LATCH_MASK = 21'h1B_033F;
   localparam logic [EV_W-1:0] READ_MASK = 21'h1B_03FF;
   localparam logic [EV_W-1:0] EVENT_RESET = 21'h00_0000;
   localparam logic [DATA_W-1:0] RDATA_RESET = 32'h0000_0000;

   // Four DMA completion sources, index order
   localparam int DMA_N = 4;
   localparam int DMA_REQUEST_SEND = 0;
   localparam int DMA_REPLY_SEND = 1;
   localparam int DMA_REQUEST_RX = 2;
   localparam int DMA_REPLY_RX = 3;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } reg_req_t;

   typedef enum logic [1:0] {
      RD_IDLE = 2'b01,
      RD_RESP = 2'b10
   } rd_state_t;

endpackage

/* event_edge_detect.sv */
// Rising edge detector for a vector of event sources
`timescale 1ns/1ns
module event_edge_detect #(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // Sources and edges
   input wire logic [WIDTH-1:0] src,
   output logic [WIDTH-1:0] rise
);
   logic [WIDTH-1:0] prev_reg;
   logic [WIDTH-1:0] prev_next;

   always_comb begin
      prev_next = src;
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         prev_reg <= '0;
      end else begin
         prev_reg <= prev_next;
      end
   end

   // A level held high counts once only
   assign rise = src & ~prev_reg;
endmodule // event_edge_detect

/* irq_event_low.sv */
// Interrupt event bits 20..0: latched events, summaries, set/clear window
`timescale 1ns/1ns
module irq_event_low
   import irq_event_pkg::*;
#(
   parameter int ISO_RX_N = 4,
   parameter int ISO_TX_N = 4
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // Register window
   input wire reg_req_t reg_req,
   output logic [DATA_W-1:0] reg_rdata,
   output logic reg_rvalid,
   // Mask register contents, low bits
   input wire logic [EV_W-1:0] int_mask,
   // Link and PHY events
   input wire logic cycle_count_lsb,
   input wire logic phy_status_irq,
   input wire logic phy_bus_reset,
   input wire logic self_id_stream_rcvd,
   input wire logic lock_reply_no_ack,
   input wire logic buffered_write_bus_err,
   input wire logic reply_packet_stored_ev,
   input wire logic request_packet_stored_ev,
   // DMA completions and their interrupt conditions
   input wire logic [DMA_N-1:0] dma_cmd_done,
   input wire logic [DMA_N-1:0] dma_irq_cond,
   // Isochronous per-context events and masks
   input wire logic [ISO_RX_N-1:0] iso_rx_event,
   input wire logic [ISO_RX_N-1:0] iso_rx_mask,
   input wire logic [ISO_TX_N-1:0] iso_tx_event,
   input wire logic [ISO_TX_N-1:0] iso_tx_mask,
   // Unmasked state for the interrupt logic
   output logic [EV_W-1:0] event_latched,
   output logic timed_receive_summary,
   output logic timed_transmit_summary
);

   function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
      addr_hit = (a == off);
   endfunction

   // Latched flags
   logic [EV_W-1:0] event_reg;
   logic [EV_W-1:0] event_next;
   // Summaries, following the contexts with one cycle lag
   logic rx_sum_reg;
   logic rx_sum_next;
   logic tx_sum_reg;
   logic tx_sum_next;
   // Cycle count LSB history
   logic lsb_reg;
   logic lsb_next;
   // Read answer
   rd_state_t rd_state_reg;
   rd_state_t rd_state_next;
   logic [DATA_W-1:0] rdata_reg;
   logic [DATA_W-1:0] rdata_next;

   logic [7:0] src_vec;
   logic [7:0] src_rise;
   logic [EV_W-1:0] hw_set;
   logic [EV_W-1:0] sw_set;
   logic [EV_W-1:0] sw_clr;
   logic [EV_W-1:0] set_all;
   logic [EV_W-1:0] view;
   logic cycle_toggle;
   logic bus_rise;
   logic win_hit;

   assign src_vec = {request_packet_stored_ev, reply_packet_stored_ev, buffered_write_bus_err,
                     lock_reply_no_ack, self_id_stream_rcvd, phy_bus_reset, phy_status_irq, 1'b0};

   event_edge_detect #(
      .WIDTH(8)
   ) u_edges (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .src(src_vec),
      .rise(src_rise)
   );

   always_comb begin
      lsb_next = cycle_count_lsb;
   end

   // either direction of the LSB counts
   assign cycle_toggle = cycle_count_lsb ^ lsb_reg;

   always_comb begin
      hw_set = '0;
      hw_set[BIT_NEW_CYCLE] = cycle_toggle;
      hw_set[BIT_PHY_REQ] = src_rise[1];
      hw_set[BIT_BUS_REINIT] = src_rise[2];
      hw_set[BIT_ID_DONE] = src_rise[3];
      hw_set[BIT_LOCK_FAIL] = src_rise[4];
      hw_set[BIT_BUF_WR_FAIL] = src_rise[5];
      hw_set[BIT_REPLY_PKT] = src_rise[6];
      hw_set[BIT_REQUEST_PKT] = src_rise[7];
      // receive descriptors, when the context asks
      hw_set[BIT_REPLY_RX_DMA] = dma_cmd_done[DMA_REPLY_RX] & dma_irq_cond[DMA_REPLY_RX];
      hw_set[BIT_REQUEST_RX_DMA] = dma_cmd_done[DMA_REQUEST_RX] & dma_irq_cond[DMA_REQUEST_RX];
      // send commands, when the context asks
      hw_set[BIT_REPLY_SEND] = dma_cmd_done[DMA_REPLY_SEND] & dma_irq_cond[DMA_REPLY_SEND];
      hw_set[BIT_REQUEST_SEND] = dma_cmd_done[DMA_REQUEST_SEND] & dma_irq_cond[DMA_REQUEST_SEND];
   end

   // software strobes reach latched bits only
   assign sw_set = (reg_req.wr && addr_hit(reg_req.addr, OFF_EVENT_SET)) ?
                   (reg_req.wdata[EV_W-1:0] & LATCH_MASK) : '0;
   assign sw_clr = (reg_req.wr && addr_hit(reg_req.addr, OFF_EVENT_CLR)) ?
                   (reg_req.wdata[EV_W-1:0] & LATCH_MASK) : '0;
   assign set_all = hw_set | sw_set;
   assign bus_rise = set_all[BIT_BUS_REINIT] & ~event_reg[BIT_BUS_REINIT];

   always_comb begin
      // a set in the clearing cycle is kept
      event_next = ((event_reg & ~sw_clr) | set_all) & LATCH_MASK;
      // identity-done drops as bus reinit rises, even over a new set
      if (bus_rise) begin
         event_next[BIT_ID_DONE] = 1'b0;
      end
   end

   always_comb begin
      rx_sum_next = |(iso_rx_event & iso_rx_mask);
      tx_sum_next = |(iso_tx_event & iso_tx_mask);
   end

   always_comb begin
      view = event_reg;
      view[BIT_RX_SUMMARY] = rx_sum_reg;
      view[BIT_TX_SUMMARY] = tx_sum_reg;
   end

   assign win_hit = addr_hit(reg_req.addr, OFF_EVENT_SET) | addr_hit(reg_req.addr, OFF_EVENT_CLR);

   always_comb begin
      rd_state_next = RD_IDLE;
      rdata_next = rdata_reg;
      case (rd_state_reg)
         RD_IDLE, RD_RESP: begin
            if (reg_req.rd) begin
               rd_state_next = RD_RESP;
               rdata_next = win_hit ? {{(DATA_W-EV_W){1'b0}}, view & int_mask & READ_MASK} : RDATA_RESET;
            end
         end
         default: begin
            rd_state_next = RD_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         event_reg <= EVENT_RESET;
         rx_sum_reg <= 1'b0;
         tx_sum_reg <= 1'b0;
         lsb_reg <= 1'b0;
         rd_state_reg <= RD_IDLE;
         rdata_reg <= RDATA_RESET;
      end else begin
         event_reg <= event_next;
         rx_sum_reg <= rx_sum_next;
         tx_sum_reg <= tx_sum_next;
         lsb_reg <= lsb_next;
         rd_state_reg <= rd_state_next;
         rdata_reg <= rdata_next;
      end
   end

   assign reg_rdata = rdata_reg;
   assign reg_rvalid = (rd_state_reg == RD_RESP);
   assign event_latched = event_reg;
   assign timed_receive_summary = rx_sum_reg;
   assign timed_transmit_summary = tx_sum_reg;

   // Checks
   chk_new_cycle_set: assert property (@(posedge core_clk) disable iff (!rst_b)
      cycle_toggle |=> event_reg[BIT_NEW_CYCLE])
      else $error("new cycle flag not set after LSB change");

   chk_phy_req_set: assert property (@(posedge core_clk) disable iff (!rst_b)
      $rose(phy_status_irq) |=> event_reg[BIT_PHY_REQ])
      else $error("phy request flag not set");

   chk_bit18_zero: assert property (@(posedge core_clk) disable iff (!rst_b)
      reg_rvalid |-> !reg_rdata[18])
      else $error("bit 18 read nonzero");

   chk_reserved_low_zero: assert property (@(posedge core_clk) disable iff (!rst_b)
      reg_rvalid |-> (reg_rdata[15:10] == 6'h00))
      else $error("bits 15 to 10 read nonzero");

   chk_bus_reinit_set: assert property (@(posedge core_clk) disable iff (!rst_b)
      $rose(phy_bus_reset) |=> event_reg[BIT_BUS_REINIT])
      else $error("bus reinit flag not set");

   chk_id_done_set: assert property (@(posedge core_clk) disable iff (!rst_b)
      ($rose(self_id_stream_rcvd) && !bus_rise) |=> event_reg[BIT_ID_DONE])
      else $error("identity done flag not set");

   chk_id_done_drop: assert property (@(posedge core_clk) disable iff (!rst_b)
      $rose(event_reg[BIT_BUS_REINIT]) |-> !event_reg[BIT_ID_DONE])
      else $error("identity done kept while bus reinit rose");

   chk_lock_fail_set: assert property (@(posedge core_clk) disable iff (!rst_b)
      $rose(lock_reply_no_ack) |=> event_reg[BIT_LOCK_FAIL])
      else $error("lock reply failure not set");

   chk_buf_write_set: assert property (@(posedge core_clk) disable iff (!rst_b)
      $rose(buffered_write_bus_err) |=> event_reg[BIT_BUF_WR_FAIL])
      else $error("buffered write failure not set");

   chk_rx_summary: assert property (@(posedge core_clk) disable iff (!rst_b)
      ##1 (rx_sum_reg == |($past(iso_rx_event) & $past(iso_rx_mask))))
      else $error("receive summary wrong");

   chk_tx_summary: assert property (@(posedge core_clk) disable iff (!rst_b)
      ##1 (tx_sum_reg == |($past(iso_tx_event) & $past(iso_tx_mask))))
      else $error("transmit summary wrong");

   chk_reply_pkt_set: assert property (@(posedge core_clk) disable iff (!rst_b)
      $rose(reply_packet_stored_ev) |=> event_reg[BIT_REPLY_PKT])
      else $error("reply packet flag not set");

   chk_request_pkt_set: assert property (@(posedge core_clk) disable iff (!rst_b)
      $rose(request_packet_stored_ev) |=> event_reg[BIT_REQUEST_PKT])
      else $error("request packet flag not set");

   chk_reply_rx_cond: assert property (@(posedge core_clk) disable iff (!rst_b)
      (!event_reg[BIT_REPLY_RX_DMA] && !sw_set[BIT_REPLY_RX_DMA])
      |=> (event_reg[BIT_REPLY_RX_DMA] ==
           ($past(dma_cmd_done[DMA_REPLY_RX]) && $past(dma_irq_cond[DMA_REPLY_RX]))))
      else $error("reply receive dma flag wrong");

   chk_request_rx_cond: assert property (@(posedge core_clk) disable iff (!rst_b)
      (!event_reg[BIT_REQUEST_RX_DMA] && !sw_set[BIT_REQUEST_RX_DMA])
      |=> (event_reg[BIT_REQUEST_RX_DMA] ==
           ($past(dma_cmd_done[DMA_REQUEST_RX]) && $past(dma_irq_cond[DMA_REQUEST_RX]))))
      else $error("request receive dma flag wrong");

   chk_reply_send_cond: assert property (@(posedge core_clk) disable iff (!rst_b)
      (dma_cmd_done[DMA_REPLY_SEND] && dma_irq_cond[DMA_REPLY_SEND]) |=> event_reg[BIT_REPLY_SEND])
      else $error("reply send flag not set");

   chk_request_send_cond: assert property (@(posedge core_clk) disable iff (!rst_b)
      (dma_cmd_done[DMA_REQUEST_SEND] && dma_irq_cond[DMA_REQUEST_SEND]) |=> event_reg[BIT_REQUEST_SEND])
      else $error("request send flag not set");

   chk_sw_set_bit: assert property (@(posedge core_clk) disable iff (!rst_b)
      (reg_req.wr && reg_req.addr == OFF_EVENT_SET && reg_req.wdata[BIT_LOCK_FAIL]) |=> event_reg[BIT_LOCK_FAIL])
      else $error("set write did not set bit");

   chk_clear_only: assert property (@(posedge core_clk) disable iff (!rst_b)
      ##1 ((($past(event_reg) & ~event_reg & ~$past(sw_clr)) & ~(EV_W'(1) << BIT_ID_DONE)) == '0))
      else $error("flag dropped without clear write");

   chk_read_masked: assert property (@(posedge core_clk) disable iff (!rst_b)
      (reg_req.rd && win_hit) |=> (reg_rvalid && reg_rdata[EV_W-1:0] == ($past(view) & $past(int_mask))))
      else $error("read not masked event state");

   chk_summary_no_write: assert property (@(posedge core_clk) disable iff (!rst_b)
      (reg_req.wr && win_hit && rx_sum_next == rx_sum_reg) |=> $stable(rx_sum_reg))
      else $error("write disturbed receive summary");

   chk_clear_works: assert property (@(posedge core_clk) disable iff (!rst_b)
      (reg_req.wr && reg_req.addr == OFF_EVENT_CLR && reg_req.wdata[BIT_PHY_REQ] && !phy_status_irq)
      |=> !event_reg[BIT_PHY_REQ])
      else $error("clear write did not clear bit");

   chk_rvalid_follows_rd: assert property (@(posedge core_clk) disable iff (!rst_b)
      ##1 (reg_rvalid == $past(reg_req.rd)))
      else $error("read answer valid out of step");

   chk_outside_reads_zero: assert property (@(posedge core_clk) disable iff (!rst_b)
      (reg_req.rd && !win_hit) |=> (reg_rvalid && reg_rdata == '0))
      else $error("read outside window not zero");

   chk_id_done_on_reset: assert property (@(posedge core_clk) disable iff (!rst_b)
      ($rose(phy_bus_reset) && !event_reg[BIT_BUS_REINIT]) |=> !event_reg[BIT_ID_DONE])
      else $error("identity done kept on bus reset");

   chk_rx_sum_unset: assert property (@(posedge core_clk) disable iff (!rst_b)
      (reg_req.wr && reg_req.addr == OFF_EVENT_SET && reg_req.wdata[BIT_RX_SUMMARY] &&
       !(|(iso_rx_event & iso_rx_mask)))
      |=> !rx_sum_reg)
      else $error("set write reached receive summary");

   chk_tx_sum_uncleared: assert property (@(posedge core_clk) disable iff (!rst_b)
      (reg_req.wr && reg_req.addr == OFF_EVENT_CLR && reg_req.wdata[BIT_TX_SUMMARY] &&
       (|(iso_tx_event & iso_tx_mask)))
      |=> tx_sum_reg)
      else $error("clear write reached transmit summary");

endmodule // irq_event_low

/* tb_top.sv */
// Self-checking bench for the low interrupt event bits
`timescale 1ns/1ns
module tb_top;
   import irq_event_pkg::*;

   logic core_clk = 1'b0;
   logic rst_b = 1'b0;
   reg_req_t req = '0;
   logic [EV_W-1:0] int_mask = '1;
   logic [6:0] src = '0;
   logic cyc_lsb = 1'b0;
   logic [DMA_N-1:0] done = '0;
   logic [DMA_N-1:0] cond = '0;
   logic [3:0] rx_ev = '0;
   logic [3:0] rx_mk = '0;
   logic [3:0] tx_ev = '0;
   logic [3:0] tx_mk = '0;
   logic [DATA_W-1:0] rdata;
   logic rvalid;
   logic [EV_W-1:0] lat;
   logic rx_sum;
   logic tx_sum;
   int n_mismatch = 0;
   int total_checks = 0;
   // Source index to flag position
   int bit_of [7] = '{BIT_PHY_REQ, BIT_BUS_REINIT, BIT_ID_DONE, BIT_LOCK_FAIL, BIT_BUF_WR_FAIL,
                      BIT_REPLY_PKT, BIT_REQUEST_PKT};

   always #5 core_clk = ~core_clk;

   irq_event_low dut (
      .core_clk(core_clk), .rst_b(rst_b), .reg_req(req), .reg_rdata(rdata), .reg_rvalid(rvalid),
      .int_mask(int_mask), .cycle_count_lsb(cyc_lsb), .phy_status_irq(src[0]), .phy_bus_reset(src[1]),
      .self_id_stream_rcvd(src[2]), .lock_reply_no_ack(src[3]), .buffered_write_bus_err(src[4]),
      .reply_packet_stored_ev(src[5]), .request_packet_stored_ev(src[6]), .dma_cmd_done(done),
      .dma_irq_cond(cond), .iso_rx_event(rx_ev), .iso_rx_mask(rx_mk), .iso_tx_event(tx_ev),
      .iso_tx_mask(tx_mk), .event_latched(lat), .timed_receive_summary(rx_sum),
      .timed_transmit_summary(tx_sum));

   task automatic results();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wait_n(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask

   task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge core_clk);
      req.wr <= 1'b1;
      req.addr <= a;
      req.wdata <= d;
      @(posedge core_clk);
      req.wr <= 1'b0;
      #1;
   endtask

   task automatic reg_rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
      @(posedge core_clk);
      req.rd <= 1'b1;
      req.addr <= a;
      @(posedge core_clk);
      req.rd <= 1'b0;
      #1;
      chk({31'h0, rvalid}, 32'h0000_0001);
      chk(rdata, exp);
   endtask

   task automatic clear_all();
      reg_wr(OFF_EVENT_CLR, 32'hFFFF_FFFF);
      chk({11'h0, lat}, 32'h0000_0000);
   endtask

   // Software set, reserved bits, masked reads, clear semantics
   task automatic t_window();
      logic [EV_W-1:0] all;
      all = LATCH_MASK & ~(21'h1 << BIT_ID_DONE);
      reg_wr(OFF_EVENT_SET, 32'hFFFF_FFFF);
      chk({11'h0, lat}, {11'h0, all});
      reg_rd(OFF_EVENT_SET, {11'h0, all});
      @(posedge core_clk);
      int_mask <= 21'h0F_0F0F;
      reg_rd(OFF_EVENT_CLR, {11'h0, all & 21'h0F_0F0F});
      @(posedge core_clk);
      int_mask <= '1;
      reg_rd(8'h88, 32'h0000_0000);
      reg_wr(OFF_EVENT_CLR, 32'h0000_0000);
      chk({11'h0, lat}, {11'h0, all});
      reg_wr(8'h88, 32'hFFFF_FFFF);
      chk({11'h0, lat}, {11'h0, all});
      reg_wr(OFF_EVENT_SET, 32'h0001_0000);
      reg_rd(OFF_EVENT_SET, {11'h0, LATCH_MASK});
      clear_all();
   endtask

   // Each link event sets its flag once per rising edge
   task automatic t_sources();
      for (int i = 0; i < 7; i++) begin
         @(posedge core_clk);
         src[i] <= 1'b1;
         wait_n(2);
         chk({11'h0, lat}, 32'h1 << bit_of[i]);
         clear_all();
         wait_n(2);
         chk({11'h0, lat}, 32'h0000_0000);
         @(posedge core_clk);
         src[i] <= 1'b0;
         wait_n(1);
      end
      @(posedge core_clk);
      src[2] <= 1'b1;
      wait_n(2);
      @(posedge core_clk);
      src[1] <= 1'b1;
      wait_n(2);
      chk({11'h0, lat}, 32'h1 << BIT_BUS_REINIT);
      @(posedge core_clk);
      src[1] <= 1'b0;
      src[2] <= 1'b0;
      clear_all();
   endtask

   // Cycle count low bit: both directions of change
   task automatic t_cycle();
      for (int k = 0; k < 2; k++) begin
         @(posedge core_clk);
         cyc_lsb <= ~cyc_lsb;
         wait_n(2);
         chk({11'h0, lat}, 32'h1 << BIT_NEW_CYCLE);
         clear_all();
      end
   endtask

   // DMA completions set only with their condition
   task automatic t_dma();
      for (int k = 0; k < DMA_N; k++) begin
         @(posedge core_clk);
         done[k] <= 1'b1;
         @(posedge core_clk);
         done[k] <= 1'b0;
         wait_n(1);
         chk({11'h0, lat}, 32'h0000_0000);
         @(posedge core_clk);
         done[k] <= 1'b1;
         cond[k] <= 1'b1;
         @(posedge core_clk);
         done[k] <= 1'b0;
         cond[k] <= 1'b0;
         wait_n(1);
         chk({11'h0, lat}, 32'h1 << k);
         clear_all();
      end
   endtask

   // Isochronous summaries follow masked context events
   task automatic t_summary();
      @(posedge core_clk);
      rx_ev <= 4'h4;
      tx_ev <= 4'h8;
      wait_n(3);
      chk({30'h0, rx_sum, tx_sum}, 32'h0000_0000);
      @(posedge core_clk);
      rx_mk <= 4'h4;
      tx_mk <= 4'h8;
      wait_n(3);
      chk({30'h0, rx_sum, tx_sum}, 32'h0000_0003);
      reg_wr(OFF_EVENT_CLR, 32'hFFFF_FFFF);
      wait_n(1);
      chk({30'h0, rx_sum, tx_sum}, 32'h0000_0003);
      chk({11'h0, lat}, 32'h0000_0000);
      reg_rd(OFF_EVENT_SET, 32'h0000_00C0);
      @(posedge core_clk);
      int_mask <= 21'h1F_FF3F;
      reg_rd(OFF_EVENT_CLR, 32'h0000_0000);
      @(posedge core_clk);
      int_mask <= '1;
      rx_ev <= 4'h0;
      tx_mk <= 4'h0;
      wait_n(3);
      chk({30'h0, rx_sum, tx_sum}, 32'h0000_0000);
   endtask

   initial begin
      #200000;
      n_mismatch++;
      results();
   end

   initial begin
      repeat (20) @(posedge core_clk);
      rst_b <= 1'b1;
      wait_n(1);
      chk({11'h0, lat}, 32'h0000_0000);
      chk(rdata, RDATA_RESET);
      chk({31'h0, rvalid}, 32'h0000_0000);
      t_window();
      t_sources();
      t_cycle();
      t_dma();
      t_summary();
      results();
   end
endmodule // tb_top
